// [rtl/eetw_pkg.sv]
// Package with constants, states and carriers for the two-wire EEPROM slave front end.
package eetw_pkg;

    // ****************************************
    // Bus framing constants
    // ****************************************
    localparam logic [3:0] EETW_BITS_PER_BYTE = 4'h8;   // Rising edges that carry data bits.
    localparam logic [3:0] EETW_ACK_SLOT      = 4'h9;   // Count after the ninth rising edge.
    localparam logic [3:0] EETW_PROT_TYPE     = 4'h6;   // Device-type code of the protection register.
    localparam int         EETW_PAGE_BYTES    = 16;     // Page buffer depth.
    localparam int         EETW_PAGE_W        = 4;      // Page offset width.
    localparam int         EETW_ADDR_W        = 9;      // Word pointer width of the largest variant.
    localparam logic [8:0] EETW_SW_PROT_LIMIT = 9'h080; // First byte above the lower protected area.

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [8:0] EETW_PTR_RST  = 9'h000;
    localparam logic [7:0] EETW_BYTE_RST = 8'h00;

    // ****************************************
    // Types
    // ****************************************
    // Sampled levels of the two bus lines, idle level is high.
    typedef struct packed {
        logic scl;
        logic sda;
    } eetw_lines_t;

    localparam eetw_lines_t EETW_LINES_IDLE = '{scl: 1'b1, sda: 1'b1};

    // Static pins: write protect and the three address straps.
    typedef struct packed {
        logic wp;
        logic a2;
        logic a1;
        logic a0;
    } eetw_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WADDR,
        ST_WDATA,
        ST_RDATA,
        ST_WAIT_STOP
    } eetw_state_t;

endpackage : eetw_pkg

// [rtl/eetw_slave.sv]
// Two-wire serial EEPROM slave: bus engine on the link clock, write-cycle timer on the system clock.
//
// Contract
// RQ1 - Both lines high means the bus is idle.
// RQ2 - Detect data falling while clock high: start.
// RQ3 - Detect data rising while clock high: stop.
// RQ4 - Bytes are shifted most significant bit first.
// RQ5 - Data changes only while clock is low.
// RQ6 - Master starts transfers only on an idle bus.
// RQ7 - Master opens with start, closes with stop.
// RQ8 - One master clock pulse per data bit.
// RQ9 - Master chooses the byte count, unbounded.
// RQ10 - Receiver pulls data low in ninth clock.
// RQ11 - No acknowledge while a write cycle runs.
// RQ12 - Read: release after eight bits, sample acknowledge.
// RQ13 - No acknowledge: stop sending, await stop.
// RQ14 - Respond only to memory or protection type code.
// RQ15 - Compare three address bits with strap pins.
// RQ16 - Large variant: lowest strap bit selects block.
// RQ17 - Direction bit one reads, zero writes.
// RQ18 - Byte write: address, word address, one data.
// RQ19 - Up to sixteen bytes committed in one cycle.
// RQ20 - Lower-area protection is one-time and permanent; here reset clears sw_prot_q.
// RQ21 - Write-protect pin high refuses every write.
// RQ22 - Straps default low through pull-downs; here the strap inputs have no pull-down.
// RQ23 - Write to protection code arms lower protection.
// RQ24 - Refused write: no data acknowledge, no cycle.
// RQ25 - Pointer advances per byte, wraps inside page; a read advances all nine pointer bits instead.
// RQ26 - Stop after write starts cycle; inputs ignored.
// RQ27 - Oversample, synchronise and filter both lines.
`timescale 1ns/100ps

module eetw_slave #(
    parameter logic [3:0] P_MEM_TYPE    = 4'h5,   // Memory device-type code; value is arbitrary.
    parameter bit         P_BIG_VARIANT = 1'b1,   // Lowest strap bit acts as word-address bit 8.
    parameter int         P_WR_CYCLES   = 1000    // System cycles of one internal write cycle.
) (
    // System clock domain
    input  wire logic i_sys_clk,
    input  wire logic i_rst_b,
    input  wire logic i_clk_en,
    // Link clock domain
    input  wire logic i_link_clk,
    // Bus pins
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_sda_o,
    output logic      o_sda_oe,
    // Static pins
    input  wire logic i_wp,
    input  wire logic i_strap_addr_bit0,
    input  wire logic i_strap_addr_bit1,
    input  wire logic i_strap_addr_bit2,
    // Status
    output logic      o_bus_idle,
    output logic      o_write_busy,
    output logic      o_sw_protect
);
    import eetw_pkg::*;

    // ****************************************
    // Link domain declarations
    // ****************************************
    logic                   rst_l_s1_q, rst_l_b;
    logic                   en_s1_q, en_l;
    logic                   dn_s1_q, dn_s2_q, dn_tgl_q;
    eetw_lines_t            ln_s1_q, ln_s2_q, ln_s3_q, ln_f_q, ln_fp_q;
    eetw_pins_t             pin_s1_q, pin_s2_q;
    eetw_state_t            state_q;
    logic [3:0]             cnt_q;
    logic [3:0]             bit_idx;
    logic [7:0]             shift_q;
    logic [7:0]             rd_byte_q;
    logic                   drive_q, mack_q, rw_q, prot_tgt_q, pend_q, idle_q, sw_prot_q, cm_tgl_q;
    logic [EETW_ADDR_W-1:0] ptr_q;
    logic [7:0]             pbuf_q [EETW_PAGE_BYTES];
    logic [EETW_PAGE_BYTES-1:0] pval_q;
    logic [7:0]             mem_q  [2**EETW_ADDR_W];
    logic                   scl_rise, scl_fall, start_p, stop_p, busy_l;
    logic                   addr_hit, ack_addr, wr_ok, acc_wd, ld_rd, commit;

    // ****************************************
    // Crossings into the link domain
    // ****************************************
    // Reset and clock enable are levels; two stages each. The first stage feeds only the second.
    always_ff @(posedge i_link_clk) begin
        rst_l_s1_q <= i_rst_b;
        rst_l_b    <= rst_l_s1_q;
        en_s1_q    <= i_clk_en;
        en_l       <= en_s1_q;
        pin_s1_q   <= '{wp: i_wp, a2: i_strap_addr_bit2, a1: i_strap_addr_bit1, a0: i_strap_addr_bit0};
        pin_s2_q   <= pin_s1_q;
        ln_s1_q    <= '{scl: i_scl, sda: i_sda};
        ln_s2_q    <= ln_s1_q;                                  // [RQ27]
        dn_s1_q    <= dn_tgl_q;
        dn_s2_q    <= dn_s1_q;
    end

    // Filter: a line level is accepted only after two equal samples, which rejects single-cycle glitches.
    always_ff @(posedge i_link_clk) begin
        if (!rst_l_b) begin
            ln_s3_q <= EETW_LINES_IDLE;
            ln_f_q  <= EETW_LINES_IDLE;
            ln_fp_q <= EETW_LINES_IDLE;
        end else if (en_l) begin
            ln_s3_q <= ln_s2_q;
            if (ln_s2_q == ln_s3_q) begin
                ln_f_q <= ln_s3_q;                              // [RQ27]
            end
            ln_fp_q <= ln_f_q;
        end
    end

    // ****************************************
    // Bus events and decisions
    // ****************************************
    // A write cycle is running while the commit toggle has not been echoed back.
    assign busy_l   = cm_tgl_q != dn_s2_q;
    assign scl_rise = en_l && ln_f_q.scl && !ln_fp_q.scl;
    assign scl_fall = en_l && !ln_f_q.scl && ln_fp_q.scl;
    assign start_p  = en_l && ln_f_q.scl && ln_fp_q.scl && !ln_f_q.sda && ln_fp_q.sda;  // [RQ2]
    assign stop_p   = en_l && ln_f_q.scl && ln_fp_q.scl && ln_f_q.sda && !ln_fp_q.sda;  // [RQ3]
    assign bit_idx  = (cnt_q == EETW_ACK_SLOT) ? 4'h0 : cnt_q;

    // Address match: type code, then straps; the large variant skips the lowest strap.
    assign addr_hit = (shift_q[7:4] == P_MEM_TYPE || shift_q[7:4] == EETW_PROT_TYPE)   // [RQ14]
                      && shift_q[3:2] == {pin_s2_q.a2, pin_s2_q.a1}                      // [RQ15]
                      && (P_BIG_VARIANT || shift_q[1] == pin_s2_q.a0);                   // [RQ16] [RQ22]
    // The protection register is write-only, so a read of it is not answered.
    assign ack_addr = addr_hit && !(shift_q[0] && shift_q[7:4] == EETW_PROT_TYPE);
    assign wr_ok    = !pin_s2_q.wp                                                       // [RQ21]
                      && (prot_tgt_q || !(sw_prot_q && ptr_q < EETW_SW_PROT_LIMIT));     // [RQ20]
    assign acc_wd   = scl_fall && cnt_q == EETW_BITS_PER_BYTE && state_q == ST_WDATA && wr_ok;
    assign ld_rd    = scl_fall && cnt_q == EETW_ACK_SLOT
                      && ((state_q == ST_ADDR && rw_q) || (state_q == ST_RDATA && mack_q));
    assign commit   = stop_p && pend_q;                                                  // [RQ26]

    // ****************************************
    // Protocol state machine
    // ****************************************
    // Data and acknowledge are driven on the detected falling edge so they change only while clock is low.
    always_ff @(posedge i_link_clk) begin
        if (!rst_l_b) begin
            state_q    <= ST_IDLE;
            cnt_q      <= 4'h0;
            shift_q    <= EETW_BYTE_RST;
            drive_q    <= 1'b0;
            mack_q     <= 1'b0;
            rw_q       <= 1'b0;
            prot_tgt_q <= 1'b0;
            idle_q     <= 1'b1;
        end else if (stop_p) begin
            state_q <= ST_IDLE;
            drive_q <= 1'b0;
            idle_q  <= 1'b1;                                    // [RQ1]
        end else if (start_p && !busy_l) begin
            // During a write cycle a start is ignored, so polling sees no acknowledge.
            state_q <= ST_ADDR;                                 // [RQ11] [RQ26]
            cnt_q   <= 4'h0;
            drive_q <= 1'b0;
            idle_q  <= 1'b0;
        end else if (state_q != ST_IDLE && state_q != ST_WAIT_STOP) begin
            if (scl_rise) begin
                if (cnt_q < EETW_BITS_PER_BYTE) begin
                    shift_q <= {shift_q[6:0], ln_f_q.sda};      // [RQ4] [RQ8]
                    cnt_q   <= cnt_q + 4'h1;
                end else begin
                    mack_q <= !ln_f_q.sda;                      // [RQ12]
                    cnt_q  <= EETW_ACK_SLOT;
                end
            end else if (scl_fall && cnt_q == EETW_BITS_PER_BYTE) begin
                unique case (state_q)
                    ST_ADDR: begin
                        drive_q    <= ack_addr;                 // [RQ10]
                        rw_q       <= shift_q[0];               // [RQ17]
                        prot_tgt_q <= shift_q[7:4] == EETW_PROT_TYPE;
                        if (!ack_addr) begin
                            state_q <= ST_WAIT_STOP;
                        end
                    end
                    ST_WADDR: begin
                        drive_q <= 1'b1;                        // [RQ18]
                    end
                    ST_WDATA: begin
                        drive_q <= wr_ok;                       // [RQ24]
                        if (!wr_ok) begin
                            state_q <= ST_WAIT_STOP;
                        end
                    end
                    ST_RDATA: begin
                        drive_q <= 1'b0;                        // [RQ12]
                    end
                    default: begin
                        drive_q <= 1'b0;
                    end
                endcase
            end else if (scl_fall && cnt_q == EETW_ACK_SLOT) begin
                cnt_q   <= 4'h0;
                drive_q <= ld_rd ? !mem_q[ptr_q][7] : 1'b0;     // [RQ4]
                unique case (state_q)
                    ST_ADDR:  state_q <= rw_q ? ST_RDATA : ST_WADDR;
                    ST_WADDR: state_q <= ST_WDATA;
                    ST_WDATA: state_q <= ST_WDATA;              // [RQ9]
                    ST_RDATA: state_q <= mack_q ? ST_RDATA : ST_WAIT_STOP;  // [RQ13]
                    default:  state_q <= ST_WAIT_STOP;
                endcase
            end else if (scl_fall && state_q == ST_RDATA) begin
                drive_q <= !rd_byte_q[3'h7 - bit_idx[2:0]];     // [RQ4] [RQ5]
            end
        end
    end

    // ****************************************
    // Word pointer, page buffer and read byte
    // ****************************************
    always_ff @(posedge i_link_clk) begin
        if (!rst_l_b) begin
            ptr_q     <= EETW_PTR_RST;
            rd_byte_q <= EETW_BYTE_RST;
            pval_q    <= '0;
            pend_q    <= 1'b0;
        end else if (start_p && !busy_l) begin
            pval_q <= '0;
            pend_q <= 1'b0;
        end else if (commit) begin
            pval_q <= '0;
            pend_q <= 1'b0;
        end else if (scl_fall && cnt_q == EETW_BITS_PER_BYTE && state_q == ST_ADDR && ack_addr) begin
            if (P_BIG_VARIANT) begin
                ptr_q[8] <= shift_q[1];                         // [RQ16]
            end
        end else if (scl_fall && cnt_q == EETW_BITS_PER_BYTE && state_q == ST_WADDR) begin
            ptr_q[7:0] <= shift_q;
        end else if (acc_wd) begin
            // Only the page offset advances; a long burst overwrites earlier bytes of the same page.
            pbuf_q[ptr_q[EETW_PAGE_W-1:0]] <= shift_q;          // [RQ19]
            pval_q[ptr_q[EETW_PAGE_W-1:0]] <= 1'b1;
            ptr_q[EETW_PAGE_W-1:0]         <= ptr_q[EETW_PAGE_W-1:0] + 4'h1;  // [RQ25]
            pend_q                         <= 1'b1;
        end else if (ld_rd) begin
            rd_byte_q <= mem_q[ptr_q];
            ptr_q     <= ptr_q + 9'h001;
        end
    end

    // ****************************************
    // Array, protection flag and commit toggle
    // ****************************************
    // All buffered bytes land together; the array holds no reset, like real storage.
    always_ff @(posedge i_link_clk) begin
        if (commit && !prot_tgt_q) begin
            for (int i = 0; i < EETW_PAGE_BYTES; i++) begin
                if (pval_q[i]) begin
                    mem_q[{ptr_q[EETW_ADDR_W-1:EETW_PAGE_W], i[EETW_PAGE_W-1:0]}] <= pbuf_q[i];  // [RQ19]
                end
            end
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (!rst_l_b) begin
            sw_prot_q <= 1'b0;
            cm_tgl_q  <= 1'b0;
        end else if (commit) begin
            cm_tgl_q <= !cm_tgl_q;                              // [RQ26]
            if (prot_tgt_q) begin
                sw_prot_q <= 1'b1;                              // [RQ23]
            end
        end
    end

    assign o_sda_o      = 1'b0;
    assign o_sda_oe     = drive_q;
    assign o_bus_idle   = idle_q;
    assign o_sw_protect = sw_prot_q;

    // ****************************************
    // System domain: internal write cycle timer
    // ****************************************
    logic        cm_s1_q, cm_s2_q, wr_busy_q;
    logic [31:0] wr_cnt_q;

    always_ff @(posedge i_sys_clk) begin
        cm_s1_q <= cm_tgl_q;
        cm_s2_q <= cm_s1_q;
    end

    // Counts one write cycle per commit toggle, then echoes the toggle back to release the bus engine.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            dn_tgl_q  <= 1'b0;
            wr_cnt_q  <= 32'h0;
            wr_busy_q <= 1'b0;
        end else if (i_clk_en) begin
            wr_busy_q <= cm_s2_q != dn_tgl_q;
            if (cm_s2_q != dn_tgl_q) begin
                if (wr_cnt_q == 32'(P_WR_CYCLES - 1)) begin
                    wr_cnt_q <= 32'h0;
                    dn_tgl_q <= cm_s2_q;
                end else begin
                    wr_cnt_q <= wr_cnt_q + 32'h1;
                end
            end
        end
    end

    assign o_write_busy = wr_busy_q;

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_byte_end;
        scl_fall && cnt_q == EETW_BITS_PER_BYTE;
    endsequence

    sequence s_ack_end;
        scl_fall && cnt_q == EETW_ACK_SLOT;
    endsequence

    a_sda_clock_low: assert property (@(posedge i_link_clk) disable iff (!rst_l_b) // [RQ5]
        $changed(drive_q) && !$past(start_p) && !$past(stop_p) |-> !ln_fp_q.scl)
        else $error("Data line changed while clock high.");

    a_start_to_addr: assert property (@(posedge i_link_clk) disable iff (!rst_l_b) // [RQ2]
        start_p && !stop_p && !busy_l |=> state_q == ST_ADDR && cnt_q == 4'h0 && !drive_q)
        else $error("Start did not open an address phase.");

    a_stop_to_idle: assert property (@(posedge i_link_clk) disable iff (!rst_l_b) // [RQ3]
        stop_p |=> state_q == ST_IDLE && idle_q && !drive_q)
        else $error("Stop did not return to idle.");

    a_busy_no_ack: assert property (@(posedge i_link_clk) disable iff (!rst_l_b) // [RQ11]
        busy_l && $past(busy_l) |-> !drive_q)
        else $error("Data line driven during write cycle.");

    a_read_msb_first: assert property (@(posedge i_link_clk) disable iff (!rst_l_b) // [RQ4]
        scl_fall && !stop_p && !start_p && state_q == ST_RDATA && cnt_q < EETW_BITS_PER_BYTE && cnt_q != 4'h0
        |=> drive_q == !rd_byte_q[3'h7 - $past(cnt_q[2:0])])
        else $error("Read bit out of order.");

    a_read_release: assert property (@(posedge i_link_clk) disable iff (!rst_l_b) // [RQ12]
        s_byte_end and state_q == ST_RDATA && !stop_p && !start_p |=> !drive_q)
        else $error("Data line not released for master acknowledge.");

    a_nack_waits: assert property (@(posedge i_link_clk) disable iff (!rst_l_b) // [RQ13]
        s_ack_end and state_q == ST_RDATA && !mack_q && !stop_p && !start_p |=> state_q == ST_WAIT_STOP && !drive_q)
        else $error("Read continued after missing acknowledge.");

    a_wp_no_data_ack: assert property (@(posedge i_link_clk) disable iff (!rst_l_b) // [RQ21]
        s_byte_end and state_q == ST_WDATA && pin_s2_q.wp && !stop_p && !start_p
        |=> !drive_q && state_q == ST_WAIT_STOP)
        else $error("Protected write was acknowledged.");

    a_sw_prot_sticky: assert property (@(posedge i_link_clk) disable iff (!rst_l_b) // [RQ20]
        sw_prot_q |=> sw_prot_q [*2])
        else $error("Lower-area protection was cleared.");

    a_page_wrap: assert property (@(posedge i_link_clk) disable iff (!rst_l_b) // [RQ25]
        acc_wd && !stop_p && !start_p
        |=> ptr_q[3:0] == $past(ptr_q[3:0]) + 4'h1 && ptr_q[8:4] == $past(ptr_q[8:4]))
        else $error("Page pointer did not advance within page.");

    a_addr_miss: assert property (@(posedge i_link_clk) disable iff (!rst_l_b) // [RQ14]
        s_byte_end and state_q == ST_ADDR && !ack_addr && !stop_p && !start_p
        |=> !drive_q ##1 state_q != ST_WADDR)
        else $error("Unmatched address was acknowledged.");

endmodule : eetw_slave

// [verification/eetw_master_model.sv]
// Behavioural two-wire bus master that drives the slave's clock and data lines.
`timescale 1ns/100ps

module eetw_master_model #(
    parameter int P_Q = 80  // System cycles per quarter bit, four link cycles.
) (
    // Clock and resolved data wire
    input  wire logic i_sys_clk,
    input  wire logic i_sda,
    // Driven lines, the data line only ever pulled low
    output logic      o_scl,
    output logic      o_sda_oe
);
    // Both lines released at time zero, so the bus starts idle.
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end

    task automatic q();
        repeat (P_Q) @(posedge i_sys_clk);
    endtask : q

    // One clock pulse per bit; data moves a quarter bit after the fall, so hold time is kept.
    task automatic bit_io(input logic b, output logic s);
        q();
        o_sda_oe <= ~b;
        q();
        o_scl <= 1'b1;
        q();
        s = i_sda;
        q();
        o_scl <= 1'b0;
    endtask : bit_io

    // Data falls while the clock is high; also used as a repeated start.
    task automatic start_c();
        q();
        o_sda_oe <= 1'b0;
        q();
        o_scl <= 1'b1;
        q();
        o_sda_oe <= 1'b1;
        q();
        o_scl <= 1'b0;
    endtask : start_c

    // Data rises while the clock is high, then the bus rests idle before anything new.
    task automatic stop_c();
        q();
        o_sda_oe <= 1'b1;
        q();
        o_scl <= 1'b1;
        q();
        o_sda_oe <= 1'b0;
        q();
        q();
    endtask : stop_c

    // Byte out MSB first, then the line is released for the acknowledge.
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask : wr_byte

    // Byte in MSB first; answering low asks for one more byte.
    task automatic rd_byte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(~more, s);
    endtask : rd_byte
endmodule : eetw_master_model

// [verification/tb_top.sv]
// Self-checking bench for the two-wire EEPROM slave against a behavioural bus master.
`timescale 1ns/100ps

module tb_top;
    import eetw_pkg::*;
    localparam logic [3:0] MEM = 4'h5;  // Memory type code; value is arbitrary.
    logic sys_clk, link_clk, rst_b, wp, scl, m_oe, sda_oe, sda, bus_idle, write_busy, sw_protect, clk_en;
    logic [2:0] straps;  // Strap levels a2, a1, a0.
    int   n_tests = 0, n_mismatch = 0, cyc = 0;

    // Open-drain wire with a pull-up: low while any party pulls it.
    assign sda = ~(m_oe | sda_oe);

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Link clock free running, phase unrelated to the system clock.
    initial begin
        link_clk = 1'b0;
        #37;
        forever #80 link_clk = ~link_clk;
    end

    eetw_slave #(.P_MEM_TYPE(MEM), .P_BIG_VARIANT(1'b1), .P_WR_CYCLES(2000)) eetw_slave_i (
        .i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_clk_en(clk_en), .i_link_clk(link_clk),
        .i_scl(scl), .i_sda(sda), .o_sda_o(), .o_sda_oe(sda_oe), .i_wp(wp),
        .i_strap_addr_bit0(straps[0]), .i_strap_addr_bit1(straps[1]), .i_strap_addr_bit2(straps[2]),
        .o_bus_idle(bus_idle), .o_write_busy(write_busy), .o_sw_protect(sw_protect));

    eetw_master_model mst (.i_sys_clk(sys_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    // A hung handshake must not stall the run forever.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic logic [7:0] adr(input logic blk, input logic rd);
        return {MEM, 1'b1, 1'b0, blk, rd};
    endfunction : adr

    task automatic wr3(input logic [7:0] a, input logic [7:0] w, input logic [7:0] d, output logic [2:0] k);
        mst.start_c();
        mst.wr_byte(a, k[2]);
        mst.wr_byte(w, k[1]);
        mst.wr_byte(d, k[0]);
        mst.stop_c();
    endtask : wr3

    task automatic wait_idle();
        for (int k = 0; k < 5000 && write_busy !== 1'b0; k++) @(posedge sys_clk);
        chk("busy falls", 8'h00, {7'h00, write_busy});
        chk("idle after stop", 8'h01, {7'h00, bus_idle});
        repeat (200) @(posedge sys_clk);
    endtask : wait_idle

    // Dummy write sets the pointer, repeated start reads one or two bytes.
    task automatic rd_at(input logic blk, input logic [7:0] w, input logic two, output logic [15:0] d);
        logic a;
        mst.start_c();
        mst.wr_byte(adr(blk, 1'b0), a);
        chk("busy after start", 8'h00, {7'h00, bus_idle});
        mst.wr_byte(w, a);
        mst.start_c();
        mst.wr_byte(adr(blk, 1'b1), a);
        chk("read addr ack", 8'h01, {7'h00, a});
        mst.rd_byte(two, d[15:8]);
        if (two) mst.rd_byte(1'b0, d[7:0]);
        mst.stop_c();
    endtask : rd_at

    task automatic t_byte_write();
        logic [2:0]  k;
        logic        a;
        logic [15:0] d;
        wr3(adr(1'b1, 1'b0), 8'h90, 8'ha5, k);
        chk("write acks", 8'h07, {5'h00, k});
        chk("busy", 8'h01, {7'h00, write_busy});
        mst.start_c();
        chk("start ignored", 8'h01, {7'h00, bus_idle});
        mst.wr_byte(adr(1'b1, 1'b0), a);
        chk("poll ack", 8'h00, {7'h00, a});
        mst.stop_c();
        wait_idle();
        rd_at(1'b1, 8'h90, 1'b0, d);
        chk("read back", 8'ha5, d[15:8]);
        $display("test byte_write done");
    endtask : t_byte_write

    task automatic t_page_wrap();
        logic        a;
        logic [15:0] d;
        mst.start_c();
        mst.wr_byte(adr(1'b1, 1'b0), a);
        mst.wr_byte(8'haf, a);
        for (int i = 0; i < 3; i++) begin
            mst.wr_byte(8'h30 + 8'(i), a);
            chk("page ack", 8'h01, {7'h00, a});
        end
        mst.stop_c();
        wait_idle();
        rd_at(1'b1, 8'ha0, 1'b1, d);
        chk("wrapped byte", 8'h31, d[15:8]);
        chk("next byte", 8'h32, d[7:0]);
        $display("test page_wrap done");
    endtask : t_page_wrap

    task automatic t_refused();
        logic [2:0] k;
        logic       a;
        wp <= 1'b1;
        wr3(adr(1'b1, 1'b0), 8'hc0, 8'h77, k);
        chk("wp acks", 8'h06, {5'h00, k});
        chk("wp no cycle", 8'h00, {7'h00, write_busy});
        wp <= 1'b0;
        mst.start_c();
        mst.wr_byte({MEM, 4'h0}, a);
        chk("strap nack", 8'h00, {7'h00, a});
        mst.stop_c();
        mst.start_c();
        mst.wr_byte(8'h3a, a);
        chk("type nack", 8'h00, {7'h00, a});
        mst.stop_c();
        $display("test refused done");
    endtask : t_refused

    task automatic t_sw_protect();
        logic [2:0] k;
        wr3({EETW_PROT_TYPE, 4'h8}, 8'h00, 8'h00, k);
        chk("prot acks", 8'h07, {5'h00, k});
        chk("armed", 8'h01, {7'h00, sw_protect});
        wait_idle();
        wr3(adr(1'b0, 1'b0), 8'h10, 8'h5a, k);
        chk("lower acks", 8'h06, {5'h00, k});
        chk("lower no cycle", 8'h00, {7'h00, write_busy});
        chk("still armed", 8'h01, {7'h00, sw_protect});
        $display("test sw_protect done");
    endtask : t_sw_protect

    initial begin
        rst_b = 1'b0;
        wp = 1'b0;
        clk_en = 1'b1;
        straps = 3'b100;
        repeat (80) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (200) @(posedge sys_clk);
        chk("idle after reset", 8'h01, {7'h00, bus_idle});
        t_byte_write();
        t_page_wrap();
        t_refused();
        t_sw_protect();
        finish_test();
    end
endmodule : tb_top
